// >>> core/trig_status_pkg.sv
package trig_status_pkg;

  // Bus shape
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_COMMAND = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_HOLDOFF = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RUN_STATE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TRIG_ACTION = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_TRIG_TEXT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVENT_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS_BYTE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_OPER_EVENT = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_QUES_EVENT = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_ERR_COUNT = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_VERSION = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_ENABLE_DEC = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_ENABLE_HEX = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_ENABLE_OCT = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_ENABLE_BIN = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h48;

  // Command codes written to the command register
  typedef enum logic [3:0] {
    CMD_CLEAR_STATUS, CMD_RESET, CMD_TRIGGER, CMD_CONT_ON, CMD_CONT_OFF,
    CMD_OPC, CMD_OPC_QUERY, CMD_ACTION_QUERY
  } command_t;

  // Holdoff codes: 0.0, 0.5 and 1.0 seconds
  typedef enum logic [1:0] {HOLD_FAST, HOLD_MEDIUM, HOLD_SLOW} holdoff_t;

  // Stored device-trigger actions; ACT_NONE is the zero-length block
  typedef enum logic [2:0] {
    ACT_NONE, ACT_INIT, ACT_INIT_WAIT_DATA, ACT_FETCH, ACT_READ, ACT_INIT_IMM
  } trig_action_t;
  localparam logic [2:0] ACT_LAST = 3'h5;

  typedef enum {RS_HOLD, RS_WAIT, RS_MEASURE} run_state_t;

  // Standard event bits
  localparam int EV_OPC = 0;
  localparam int EV_CME = 5;
  localparam int EV_PON = 7;
  localparam logic [7:0] EV_EXT_MASK = 8'h5e;

  // Status byte bits
  localparam int SB_EAV = 2;
  localparam int SB_QSB = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_OSB = 7;

  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_MEAS_DONE = 0;
  localparam int IRQ_TRIGGER = 1;
  localparam int IRQ_REJECT = 2;
  localparam int IRQ_ESB_RISE = 3;

  // Reset values and limits
  localparam holdoff_t HOLDOFF_RST = HOLD_FAST;
  localparam trig_action_t ACTION_RST = ACT_INIT_IMM;
  localparam logic [7:0] ENABLE_POR = 8'h00;
  localparam logic [4:0] ERR_MAX = 5'h1e;
  localparam logic [7:0] ENABLE_MAX = 8'hff;

  // Version answer, BCD year and digit; the value is arbitrary
  localparam logic [15:0] VERSION_YEAR_DEF = 16'h2000;
  localparam logic [3:0] VERSION_REV_DEF = 4'h0;

  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int HOLDOFF_MEDIUM_MS = 500;
  localparam int HOLDOFF_SLOW_MS = 1000;
  localparam int HOLDOFF_MEDIUM_CYC = (CLK_HZ / 1000) * HOLDOFF_MEDIUM_MS;
  localparam int HOLDOFF_SLOW_CYC = (CLK_HZ / 1000) * HOLDOFF_SLOW_MS;

endpackage

// >>> core/status_trigger_command_logic.sv
// How it works
// - In continuous mode, measurements are spaced by fast, medium or slow holdoff.
// - Holdoff accepts only the three defined codes; others are rejected.
// - With continuous mode off the holdoff setting has no effect.
// - Reset or continuous off enters hold; only trigger, GET or continuous on restarts.
// - Version query answers year in four BCD digits plus one version digit.
// - Clear status empties error count and standard, operation, questionable events.
// - Clear status leaves settings and stored data untouched.
// - Clear status cancels pending operation-complete command and query.
// - Clear status right after a terminator also flushes the output queue.
// - Clear status drops the displayed error and any open menu.
// - Trigger action is stored, run on GET or trigger, returned as block.
// - Zero-length trigger action makes GET and trigger do nothing.
// - Unused event enable bits are discarded on write and read as zero.
// - Status byte bit 5 is OR of enabled standard event bits.
// - Event enable takes 0 to 255, clears at power-on, survives reset.
// - Event enable can be written in decimal, hex, octal or binary digits.
// - Standard event bits in EV_EXT_MASK set on condition rising edge and stay until read.
// - Event register clears on clear status, read and power-on; then records power-on.
// - Event register reads as 0 to 255 with unused bits zero.
`timescale 1ns/1ps
`default_nettype none

module status_trigger_command_logic
  import trig_status_pkg::*;
#(
  parameter int HOLD_MED_CYC = HOLDOFF_MEDIUM_CYC,
  parameter int HOLD_SLOW_CYC = HOLDOFF_SLOW_CYC,
  parameter logic [15:0] VERSION_YEAR = VERSION_YEAR_DEF,
  parameter logic [3:0] VERSION_REV = VERSION_REV_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Remote interface events
  input wire logic get_msg,
  input wire logic msg_term,
  input wire logic mav,
  output logic out_queue_flush,
  output logic opc_reply,
  // Measurement core
  input wire logic measure_done,
  output logic measure_start,
  output logic trigger_fire,
  output logic [2:0] trigger_action,
  // Status sources
  input wire logic [7:0] event_cond,
  input wire logic [15:0] oper_event,
  input wire logic [15:0] ques_event,
  // Front panel and summaries
  output logic clear_display,
  output logic event_summary,
  output logic irq
);

  typedef struct packed {
    run_state_t st;
    logic cont;
    holdoff_t holdoff;
    logic [31:0] wait_cnt;
    trig_action_t action;
    logic [4:0] text_ptr;
    logic [7:0] ese;
    logic [7:0] esr;
    logic [7:0] cond_q;
    logic pon_pending;
    logic [15:0] oper_ev;
    logic [15:0] ques_ev;
    logic [4:0] err_count;
    logic opc_pend;
    logic opcq_pend;
    logic after_term;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic measure_start;
    logic trigger_fire;
    logic [2:0] trigger_action;
    logic out_queue_flush;
    logic clear_display;
    logic opc_reply;
    logic esb;
  } state_t;

  state_t s;
  state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] holdoff_cycles(input holdoff_t h);
    logic [31:0] c;
    case (h)
      HOLD_MEDIUM: c = 32'(HOLD_MED_CYC - 1);
      HOLD_SLOW: c = 32'(HOLD_SLOW_CYC - 1);
      default: c = 32'h0000_0000;
    endcase
    return c;
  endfunction

  // Eight digits, one per nibble, most significant first; bit 32 flags a bad digit
  function automatic logic [32:0] digits_value(input logic [31:0] d, input logic [4:0] radix);
    logic [31:0] v;
    logic bad;
    logic [3:0] dig;
    v = 32'h0000_0000;
    bad = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      dig = d[4*i +: 4];
      if ({1'b0, dig} >= radix) begin
        bad = 1'b1;
      end
      v = 32'(v * {27'h0, radix}) + {28'h0, dig};
    end
    return {bad, v};
  endfunction

  // Byte i of the block answer, bit 8 marks the final newline sent with EOI
  function automatic logic [8:0] action_byte(input trig_action_t a, input logic [4:0] i);
    logic [8*21-1:0] txt;
    logic [8*21-1:0] sh;
    int n;
    txt = '0;
    n = 3;
    case (a)
      ACT_INIT: begin txt = (8*21)'("#14INIT\n"); n = 8; end
      ACT_INIT_WAIT_DATA: begin txt = (8*21)'("#216INIT:*WAI;:DATA?\n"); n = 21; end
      ACT_FETCH: begin txt = (8*21)'("#15FETC?\n"); n = 9; end
      ACT_READ: begin txt = (8*21)'("#15READ?\n"); n = 9; end
      ACT_INIT_IMM: begin txt = (8*21)'("#18INIT:IMM\n"); n = 12; end
      default: begin txt = (8*21)'("#0\n"); n = 3; end
    endcase
    sh = txt >> (8 * (n - 1 - int'(i)));
    return {(int'(i) == n - 1), sh[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic setup, wr, rd, do_cls, do_rst, do_trg, cont_on, cont_off, reject, start, opc_set;
    logic [7:0] esr_set, esr_clr;
    logic [15:0] oper_clr, ques_clr;
    logic [IRQ_W-1:0] irq_ev, irq_clr;
    logic [32:0] num;
    logic [4:0] radix;
    logic [8:0] tb;
    setup = psel && !penable;
    wr = psel && penable && s.pready && pwrite;
    rd = psel && penable && s.pready && !pwrite;
    do_cls = 1'b0;
    do_rst = 1'b0;
    do_trg = get_msg;
    cont_on = 1'b0;
    cont_off = 1'b0;
    reject = 1'b0;
    start = 1'b0;
    opc_set = 1'b0;
    esr_set = 8'h00;
    esr_clr = 8'h00;
    oper_clr = 16'h0000;
    ques_clr = 16'h0000;
    irq_ev = '0;
    irq_clr = '0;
    num = '0;
    radix = 5'd10;
    tb = action_byte(s.action, s.text_ptr);

    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.measure_start = 1'b0;
    next_s.trigger_fire = 1'b0;
    next_s.out_queue_flush = 1'b0;
    next_s.clear_display = 1'b0;
    next_s.opc_reply = 1'b0;
    next_s.cond_q = event_cond;

    // Answer in the first access cycle; read data is a snapshot taken at setup
    if (setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        OFF_COMMAND, OFF_ENABLE_DEC, OFF_ENABLE_HEX, OFF_ENABLE_OCT, OFF_ENABLE_BIN, OFF_IRQ_CLEAR:
          next_s.pslverr = !pwrite;
        OFF_HOLDOFF: next_s.prdata = {30'h0, s.holdoff};
        OFF_RUN_STATE: next_s.prdata = {27'h0, s.opcq_pend, s.opc_pend, s.st == RS_MEASURE,
                                        s.st == RS_HOLD, s.cont};
        OFF_TRIG_ACTION: next_s.prdata = {29'h0, s.action};
        OFF_TRIG_TEXT: next_s.prdata = {23'h0, tb};
        OFF_EVENT_ENABLE: next_s.prdata = {24'h0, s.ese};
        OFF_EVENT_STATUS: next_s.prdata = {24'h0, s.esr};
        OFF_STATUS_BYTE: next_s.prdata = {24'h0, |s.oper_ev, 1'b0, s.esb, mav, |s.ques_ev,
                                          s.err_count != 5'h00, 2'b00};
        OFF_OPER_EVENT: next_s.prdata = {16'h0, s.oper_ev};
        OFF_QUES_EVENT: next_s.prdata = {16'h0, s.ques_ev};
        OFF_ERR_COUNT: next_s.prdata = {27'h0, s.err_count};
        OFF_VERSION: next_s.prdata = {VERSION_YEAR, 12'h000, VERSION_REV};
        OFF_IRQ_STATUS: next_s.prdata = {28'h0, s.irq_status};
        OFF_IRQ_ENABLE: next_s.prdata = {28'h0, s.irq_enable};
        default: next_s.pslverr = 1'b1;
      endcase
      if (pwrite && paddr inside {OFF_RUN_STATE, OFF_TRIG_TEXT, OFF_EVENT_STATUS, OFF_STATUS_BYTE,
          OFF_OPER_EVENT, OFF_QUES_EVENT, OFF_ERR_COUNT, OFF_VERSION, OFF_IRQ_STATUS}) begin
        next_s.pslverr = 1'b1;
      end
    end

    // Read side effects clear only what was reported
    if (rd && !s.pslverr) begin
      case (paddr)
        OFF_EVENT_STATUS: esr_clr = s.prdata[7:0];
        OFF_OPER_EVENT: oper_clr = s.prdata[15:0];
        OFF_QUES_EVENT: ques_clr = s.prdata[15:0];
        OFF_TRIG_TEXT: next_s.text_ptr = tb[8] ? 5'h00 : s.text_ptr + 5'h01;
        default: ;
      endcase
    end

    if (wr && !s.pslverr) begin
      next_s.after_term = 1'b0;
      case (paddr)
        OFF_COMMAND: begin
          case (pwdata[3:0])
            CMD_CLEAR_STATUS: do_cls = 1'b1;
            CMD_RESET: do_rst = 1'b1;
            CMD_TRIGGER: do_trg = 1'b1;
            CMD_CONT_ON: cont_on = 1'b1;
            CMD_CONT_OFF: cont_off = 1'b1;
            CMD_OPC: next_s.opc_pend = 1'b1;
            CMD_OPC_QUERY: next_s.opcq_pend = 1'b1;
            CMD_ACTION_QUERY: next_s.text_ptr = 5'h00;
            default: reject = 1'b1;
          endcase
        end
        OFF_HOLDOFF: begin
          if (pwdata[31:2] == 30'h0 && pwdata[1:0] != 2'b11) begin
            next_s.holdoff = holdoff_t'(pwdata[1:0]);
          end else begin
            reject = 1'b1;
          end
        end
        OFF_TRIG_ACTION: begin
          if (pwdata[31:3] == 29'h0 && pwdata[2:0] <= ACT_LAST) begin
            next_s.action = trig_action_t'(pwdata[2:0]);
            next_s.text_ptr = 5'h00;
          end else begin
            reject = 1'b1;
          end
        end
        OFF_EVENT_ENABLE: next_s.ese = pwdata[7:0];
        OFF_ENABLE_DEC, OFF_ENABLE_HEX, OFF_ENABLE_OCT, OFF_ENABLE_BIN: begin
          case (paddr)
            OFF_ENABLE_HEX: radix = 5'd16;
            OFF_ENABLE_OCT: radix = 5'd8;
            OFF_ENABLE_BIN: radix = 5'd2;
            default: radix = 5'd10;
          endcase
          num = digits_value(pwdata, radix);
          if (!num[32] && num[31:0] <= {24'h0, ENABLE_MAX}) begin
            next_s.ese = num[7:0];
          end else begin
            reject = 1'b1;
          end
        end
        OFF_IRQ_CLEAR: irq_clr = pwdata[IRQ_W-1:0];
        OFF_IRQ_ENABLE: next_s.irq_enable = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    if (msg_term) begin
      next_s.after_term = 1'b1;
    end

    if (reject) begin
      irq_ev[IRQ_REJECT] = 1'b1;
      if (s.err_count != ERR_MAX) begin
        next_s.err_count = s.err_count + 5'h01;
      end
    end

    // run stored action on GET or trigger
    if (do_trg && s.action != ACT_NONE) begin
      next_s.trigger_fire = 1'b1;
      next_s.trigger_action = s.action;
      irq_ev[IRQ_TRIGGER] = 1'b1;
    end

    if (cont_on) begin
      next_s.cont = 1'b1;
    end

    // Measurement pacing
    case (s.st)
      RS_HOLD: begin
        start = cont_on || (do_trg && s.action != ACT_NONE);
      end
      RS_WAIT: begin
        if (s.wait_cnt == 32'h0000_0000 || (do_trg && s.action != ACT_NONE)) begin
          start = 1'b1;
        end else begin
          next_s.wait_cnt = s.wait_cnt - 32'h0000_0001;
        end
      end
      RS_MEASURE: begin
        if (measure_done) begin
          irq_ev[IRQ_MEAS_DONE] = 1'b1;
          opc_set = s.opc_pend;
          next_s.opc_pend = 1'b0;
          next_s.opc_reply = s.opcq_pend;
          next_s.opcq_pend = 1'b0;
          if (s.cont) begin
            next_s.st = RS_WAIT;
            next_s.wait_cnt = holdoff_cycles(s.holdoff);
          end else begin
            next_s.st = RS_HOLD;
          end
        end
      end
      default: next_s.st = RS_HOLD;
    endcase
    if (start) begin
      next_s.st = RS_MEASURE;
      next_s.measure_start = 1'b1;
    end

    // reset and continuous off enter hold
    if (do_rst || cont_off) begin
      next_s.st = RS_HOLD;
      next_s.cont = 1'b0;
      next_s.measure_start = 1'b0;
    end
    if (do_rst) begin
      next_s.holdoff = HOLDOFF_RST;
      next_s.action = ACTION_RST;
      next_s.text_ptr = 5'h00;
      next_s.opc_pend = 1'b0;
      next_s.opcq_pend = 1'b0;
    end

    if (do_cls) begin
      esr_clr = 8'hff;
      oper_clr = 16'hffff;
      ques_clr = 16'hffff;
      next_s.err_count = 5'h00;
      next_s.opc_pend = 1'b0;
      next_s.opcq_pend = 1'b0;
      opc_set = 1'b0;
      next_s.opc_reply = 1'b0;
      next_s.out_queue_flush = s.after_term;
      next_s.clear_display = 1'b1;
    end

    // rising condition sets; set wins over clear
    esr_set = (event_cond & ~s.cond_q) & EV_EXT_MASK;
    esr_set[EV_OPC] = opc_set;
    esr_set[EV_CME] = reject;
    // power-on bit recorded after the power-on clear
    esr_set[EV_PON] = s.pon_pending;
    next_s.pon_pending = 1'b0;
    next_s.esr = (s.esr & ~esr_clr) | esr_set;
    next_s.oper_ev = (s.oper_ev & ~oper_clr) | oper_event;
    next_s.ques_ev = (s.ques_ev & ~ques_clr) | ques_event;

    next_s.esb = |(next_s.esr & next_s.ese);
    irq_ev[IRQ_ESB_RISE] = next_s.esb && !s.esb;

    next_s.irq_status = (s.irq_status & ~irq_clr) | irq_ev;
    next_s.irq = |(next_s.irq_status & next_s.irq_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.st <= RS_HOLD;
      s.holdoff <= HOLDOFF_RST;
      s.action <= ACTION_RST;
      s.ese <= ENABLE_POR;
      s.esr <= 8'h00;
      s.pon_pending <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign out_queue_flush = s.out_queue_flush;
  assign opc_reply = s.opc_reply;
  assign measure_start = s.measure_start;
  assign trigger_fire = s.trigger_fire;
  assign trigger_action = s.trigger_action;
  assign clear_display = s.clear_display;
  assign event_summary = s.esb;
  assign irq = s.irq;

endmodule // status_trigger_command_logic

`default_nettype wire

// >>> test/status_trigger_command_logic_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module status_trigger_command_logic_asserts
  import trig_status_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Observed outputs
  input wire logic out_queue_flush,
  input wire logic opc_reply,
  input wire logic measure_start,
  input wire logic trigger_fire,
  input wire logic [2:0] trigger_action,
  input wire logic clear_display,
  input wire logic event_summary
);
  logic cmd_wr;
  logic cls_wr;
  logic rd_done;
  assign cmd_wr = pready && pwrite && paddr == OFF_COMMAND;
  assign cls_wr = cmd_wr && pwdata[3:0] == CMD_CLEAR_STATUS;
  assign rd_done = pready && !pwrite;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  enable_read_a: assert property (
    rd_done && paddr == OFF_EVENT_ENABLE |-> prdata[31:8] == 24'h00_0000)
    else $error("Enable mask read shows upper bits");
  esr_read_a: assert property (
    rd_done && paddr == OFF_EVENT_STATUS |-> prdata[31:8] == 24'h00_0000)
    else $error("Event register read shows upper bits");
  summary_off_a: assert property (
    pready && pwrite && paddr == OFF_EVENT_ENABLE && pwdata[7:0] == 8'h00 |-> ##[1:3] !event_summary)
    else $error("Summary stays high with empty mask");
  hold_entry_a: assert property (
    cmd_wr && (pwdata[3:0] == CMD_CONT_OFF || pwdata[3:0] == CMD_RESET) |=> !measure_start [*2])
    else $error("Measurement started after hold entry");
  no_action_a: assert property (
    trigger_fire |-> trigger_action != ACT_NONE)
    else $error("Trigger fired with empty action");
  flush_cause_a: assert property (
    out_queue_flush |-> $past(cls_wr))
    else $error("Output queue flushed without clear status");
  display_clear_a: assert property (
    cls_wr |=> clear_display)
    else $error("Display not cleared by clear status");
  opc_cancel_a: assert property (
    cls_wr |=> !opc_reply)
    else $error("Completion reply after clear status");

endmodule // status_trigger_command_logic_asserts

bind status_trigger_command_logic status_trigger_command_logic_asserts u_asserts (
  .clk(clk),
  .reset(reset),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .out_queue_flush(out_queue_flush),
  .opc_reply(opc_reply),
  .measure_start(measure_start),
  .trigger_fire(trigger_fire),
  .trigger_action(trigger_action),
  .clear_display(clear_display),
  .event_summary(event_summary)
);

`default_nettype wire

// >>> test/meas_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module meas_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Measurement handshake
  input wire logic measure_start,
  input wire logic [3:0] lat,
  output logic measure_done
);
  logic [3:0] cnt;

  // Done comes lat+1 cycles after the start pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 4'h0;
      measure_done <= 1'b0;
    end else begin
      measure_done <= (cnt == 4'h1);
      if (measure_start)
        cnt <= lat;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule // meas_core_model

`default_nettype wire

// >>> test/tb_status_trigger_command_logic.sv
`timescale 1ns/1ps
`default_nettype none

module tb_status_trigger_command_logic
  import trig_status_pkg::*;
;
  localparam int MED = 5;
  localparam int SLOW = 10;
  localparam logic [15:0] VER_Y = 16'h2024;
  localparam logic [3:0] VER_R = 4'h3;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic get_msg, msg_term, mav, out_queue_flush, opc_reply, measure_done, measure_start, trigger_fire;
  logic clear_display, event_summary, irq;
  logic [2:0] trigger_action;
  logic [7:0] event_cond;
  logic [15:0] oper_event, ques_event;
  logic [3:0] lat;
  int error_cnt = 0, checks_done = 0, cyc = 0, starts = 0, fires = 0, flushes = 0, clears = 0;
  int prev_start = 0, last_start = 0, base;
  int gap_exp [3] = '{5, 3 + MED + 1, 3 + SLOW + 1};
  logic [ADDR_W-1:0] radix_off [4] = '{OFF_ENABLE_DEC, OFF_ENABLE_HEX, OFF_ENABLE_OCT, OFF_ENABLE_BIN};
  logic [31:0] radix_val [4] = '{32'h0000_0200, 32'h0000_00a5, 32'h0000_0377, 32'h0101_0101};
  logic [31:0] radix_exp [4] = '{32'h0000_00c8, 32'h0000_00a5, 32'h0000_00ff, 32'h0000_0055};
  logic [8:0] txt [9] = '{9'h023, 9'h031, 9'h035, 9'h046, 9'h045, 9'h054, 9'h043, 9'h03f, 9'h10a};

  status_trigger_command_logic #(.HOLD_MED_CYC(MED), .HOLD_SLOW_CYC(SLOW), .VERSION_YEAR(VER_Y),
    .VERSION_REV(VER_R)) DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .get_msg(get_msg),
    .msg_term(msg_term), .mav(mav), .out_queue_flush(out_queue_flush), .opc_reply(opc_reply),
    .measure_done(measure_done), .measure_start(measure_start), .trigger_fire(trigger_fire),
    .trigger_action(trigger_action), .event_cond(event_cond), .oper_event(oper_event),
    .ques_event(ques_event), .clear_display(clear_display), .event_summary(event_summary), .irq(irq));
  meas_core_model u_core (.clk(clk), .reset(reset), .measure_start(measure_start), .lat(lat),
    .measure_done(measure_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (measure_start === 1'b1) begin
      prev_start <= last_start;
      last_start <= cyc;
      starts <= starts + 1;
    end
    if (trigger_fire === 1'b1)
      fires <= fires + 1;
    if (out_queue_flush === 1'b1)
      flushes <= flushes + 1;
    if (clear_display === 1'b1)
      clears <= clears + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    check(n, rd, e);
  endtask
  task automatic cmd(input command_t c);
    wr(OFF_COMMAND, 32'(c));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, get_msg, msg_term, mav} <= {1'b1, 46'h0};
    {event_cond, oper_event, ques_event, lat} <= {40'h0, 4'h2};
    tick(4);
    reset <= 1'b0;
    rd_chk("pon event", OFF_EVENT_STATUS, 32'h0000_0080);
    rd_chk("event read clear", OFF_EVENT_STATUS, 32'h0000_0000);
    rd_chk("enable por", OFF_EVENT_ENABLE, 32'h0000_0000);
    rd_chk("holdoff rst", OFF_HOLDOFF, 32'h0000_0000);
    rd_chk("action rst", OFF_TRIG_ACTION, 32'h0000_0005);
    rd_chk("version", OFF_VERSION, {VER_Y, 12'h000, VER_R});
    apb(1'b0, 8'h4c, '0);
    check("unmapped err", 32'(er), 32'h0000_0001);
    // Enable mask entry, range and summary
    wr(OFF_IRQ_ENABLE, 32'h0000_0004);
    wr(OFF_EVENT_ENABLE, 32'h0000_01ff);
    rd_chk("enable mask", OFF_EVENT_ENABLE, 32'h0000_00ff);
    for (int i = 0; i < 4; i++) begin
      wr(radix_off[i], radix_val[i]);
      rd_chk("radix enable", OFF_EVENT_ENABLE, radix_exp[i]);
    end
    check("irq idle", 32'(irq), 32'h0000_0000);
    wr(OFF_ENABLE_DEC, 32'h0000_0256);
    rd_chk("range reject", OFF_EVENT_ENABLE, 32'h0000_0055);
    rd_chk("err count", OFF_ERR_COUNT, 32'h0000_0001);
    check("irq raised", 32'(irq), 32'h0000_0001);
    wr(OFF_IRQ_ENABLE, '0);
    tick(2);
    check("irq masked", 32'(irq), 32'h0000_0000);
    wr(OFF_IRQ_ENABLE, 32'h0000_0004);
    tick(2);
    check("irq unmasked", 32'(irq), 32'h0000_0001);
    wr(OFF_IRQ_CLEAR, 32'h0000_0004);
    tick(2);
    check("irq cleared", 32'(irq), 32'h0000_0000);
    mav <= 1'b1;
    wr(OFF_EVENT_ENABLE, 32'h0000_0020);
    tick(2);
    check("summary", 32'(event_summary), 32'h0000_0001);
    rd_chk("status byte", OFF_STATUS_BYTE, 32'h0000_0034);
    rd_chk("cme event", OFF_EVENT_STATUS, 32'h0000_0020);
    tick(2);
    check("summary after read", 32'(event_summary), 32'h0000_0000);
    // Sticky bit outlives its condition; bit 0 is not an external source
    event_cond <= 8'h03;
    tick(3);
    event_cond <= 8'h00;
    tick(3);
    rd_chk("sticky event", OFF_EVENT_STATUS, 32'h0000_0002);
    // Clear status, first right after a terminator
    {oper_event, ques_event, event_cond} <= {16'h0101, 16'h0010, 8'h04};
    tick(1);
    {oper_event, ques_event} <= '0;
    cmd(CMD_OPC);
    cmd(CMD_OPC_QUERY);
    msg_term <= 1'b1;
    tick(1);
    msg_term <= 1'b0;
    cmd(CMD_CLEAR_STATUS);
    tick(2);
    check("flush", flushes, 1);
    check("display clear", clears, 1);
    rd_chk("errors cleared", OFF_ERR_COUNT, '0);
    rd_chk("events cleared", OFF_EVENT_STATUS, '0);
    rd_chk("oper cleared", OFF_OPER_EVENT, '0);
    rd_chk("ques cleared", OFF_QUES_EVENT, '0);
    rd_chk("opc idle", OFF_RUN_STATE, 32'h0000_0002);
    rd_chk("enable kept", OFF_EVENT_ENABLE, 32'h0000_0020);
    cmd(CMD_CLEAR_STATUS);
    tick(2);
    check("no flush", flushes, 1);
    event_cond <= 8'h00;
    // Pacing per holdoff code, then hold
    for (int h = 0; h < 3; h++) begin
      wr(OFF_HOLDOFF, 32'(h));
      cmd(CMD_CONT_ON);
      base = starts + 3;
      for (int n = 0; n < 200 && starts < base; n++)
        tick(1);
      check("pacing gap", last_start - prev_start, gap_exp[h]);
      cmd(CMD_CONT_OFF);
      tick(2);
      base = starts;
      tick(40);
      check("hold entered", starts, base);
    end
    wr(OFF_HOLDOFF, 32'h0000_0003);
    rd_chk("holdoff reject", OFF_HOLDOFF, 32'h0000_0002);
    rd_chk("reject counted", OFF_ERR_COUNT, 32'h0000_0001);
    base = starts;
    cmd(CMD_TRIGGER);
    tick(40);
    check("single shot", starts, base + 1);
    cmd(CMD_CONT_ON);
    tick(3);
    cmd(CMD_RESET);
    tick(2);
    base = starts;
    tick(40);
    check("reset holds", starts, base);
    rd_chk("enable survives", OFF_EVENT_ENABLE, 32'h0000_0020);
    // Trigger action, slow core
    lat <= 4'h9;
    wr(OFF_TRIG_ACTION, '0);
    base = fires;
    cmd(CMD_TRIGGER);
    get_msg <= 1'b1;
    tick(1);
    get_msg <= 1'b0;
    tick(20);
    check("empty action", fires, base);
    wr(OFF_TRIG_ACTION, 32'h0000_0003);
    cmd(CMD_TRIGGER);
    tick(20);
    get_msg <= 1'b1;
    tick(1);
    get_msg <= 1'b0;
    tick(3);
    check("action fires", fires, base + 2);
    check("action code", 32'(trigger_action), 32'h0000_0003);
    wr(OFF_TRIG_ACTION, 32'h0000_0006);
    rd_chk("action reject", OFF_TRIG_ACTION, 32'h0000_0003);
    rd_chk("action text", OFF_TRIG_TEXT, 32'(txt[0]));
    cmd(CMD_ACTION_QUERY);
    for (int i = 0; i < 9; i++)
      rd_chk("action text", OFF_TRIG_TEXT, 32'(txt[i]));
    wr(OFF_EVENT_ENABLE, '0);
    tick(4);
    wrap_up;
  end

  initial begin
    tick(20000);
    error_cnt++;
    wrap_up;
  end
endmodule // tb_status_trigger_command_logic

`default_nettype wire
